// ### shared/icns_pkg.sv
// Package of constants for the serial configuration slave with non-volatile store.
package icns_pkg;
    localparam logic [6:0] SLAVE_ADDR     = 7'h75;
    localparam logic [4:0] HS_CODE_TOP    = 5'h01;
    localparam logic [7:0] REG_CONFIG     = 8'h01;
    localparam logic [7:0] REG_FLOOR      = 8'h02;
    localparam logic [7:0] REG_ROOF       = 8'h03;
    localparam logic [7:0] REG_ILIM       = 8'h04;
    localparam logic [7:0] REG_STATUS     = 8'h05;
    localparam logic [7:0] REG_NVCTRL     = 8'hff;
    localparam logic [7:0] MASK_CONFIG    = 8'hef;
    localparam logic [7:0] MASK_FLOOR     = 8'h1f;
    localparam logic [7:0] MASK_ROOF      = 8'h1f;
    localparam logic [7:0] MASK_ILIM      = 8'h3f;
    localparam logic [7:0] NV_STORE_MASK  = 8'h6f;
    localparam logic [7:0] NV_ILIM_MASK   = 8'h1f;
    localparam int         NV_TRIG_BIT    = 7;
    localparam int         NV_WP_BIT      = 6;
    localparam int         NV_LOCK_BIT    = 5;
    localparam logic [7:0] NVCTRL_RESET   = 8'h00;
    localparam logic [7:0] FLOOR_DEFAULT  = 8'h06;
    localparam logic [7:0] ROOF_DEFAULT   = 8'h0a;
    localparam logic [7:0] ILIM_DEFAULT   = 8'h1b;
    localparam logic [7:0] CONFIG_DEFAULT = 8'h01;
    localparam int         NV_WRITE_NS    = 1000;
    localparam int         CLK_PERIOD_NS  = 8;
    localparam int         NV_WRITE_CYC   = (NV_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int         LOAD_CYC       = 4;
endpackage

// ### core/icns_sync.sv
// Two-flop synchroniser for the serial clock and data pins.
`timescale 1ns/1ps
`default_nettype none
module icns_sync (
    input  wire logic clk_sys,
    input  wire logic rst_b,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_q;

    // Pins idle high, so the chain resets high to avoid a false start.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            meta_q   <= 1'b1;
            sync_out <= 1'b1;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // icns_sync
`default_nettype wire

// ### core/icns_nvstore.sv
// Non-volatile configuration store model with a write lock that holds until reset.
`timescale 1ns/1ps
`default_nettype none
module icns_nvstore (
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic       prog_req,
    input  wire logic [7:0] prog_config,
    input  wire logic [7:0] prog_floor,
    input  wire logic [7:0] prog_roof,
    input  wire logic [7:0] prog_ilim,
    input  wire logic       prog_wp,
    output logic            prog_done,
    output logic [7:0]      nv_config,
    output logic [7:0]      nv_floor,
    output logic [7:0]      nv_roof,
    output logic [7:0]      nv_ilim,
    output logic            nv_locked
);
    logic [7:0]  mem_q [4];
    logic        lock_q;
    logic        busy_q;
    logic [15:0] cnt_q;

    // The logic reset stands in for power-up, so the cells restart at factory defaults.
    // A model that must keep its cells across resets would drop the array's reset branch.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            busy_q    <= 1'b0;
            cnt_q     <= 16'h0000;
            prog_done <= 1'b0;
        end else begin
            prog_done <= 1'b0;
            if (busy_q) begin
                if (cnt_q == 16'(icns_pkg::NV_WRITE_CYC - 1)) begin
                    busy_q    <= 1'b0;
                    prog_done <= 1'b1;
                end
                cnt_q <= cnt_q + 16'h0001;
            end else if (prog_req) begin
                busy_q <= 1'b1;
                cnt_q  <= 16'h0000;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mem_q[0] <= icns_pkg::CONFIG_DEFAULT;
            mem_q[1] <= icns_pkg::FLOOR_DEFAULT;
            mem_q[2] <= icns_pkg::ROOF_DEFAULT;
            mem_q[3] <= icns_pkg::ILIM_DEFAULT;
            lock_q   <= 1'b0;
        end else if (prog_req && !busy_q && !lock_q) begin
            mem_q[0] <= prog_config;
            mem_q[1] <= prog_floor;
            mem_q[2] <= prog_roof;
            mem_q[3] <= prog_ilim;
            lock_q   <= prog_wp;
        end
    end

    assign nv_config = mem_q[0];
    assign nv_floor  = mem_q[1];
    assign nv_roof   = mem_q[2];
    assign nv_ilim   = mem_q[3];
    assign nv_locked = lock_q;
endmodule // icns_nvstore
`default_nettype wire

// ### core/icns_slave.sv
// Serial-bus configuration slave with register file and non-volatile store control.
`timescale 1ns/1ps
`default_nettype none
module icns_slave (
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_b,
    input  wire logic [7:0] status_in,
    output logic [7:0]      device_config,
    output logic [7:0]      boost_floor_threshold,
    output logic [7:0]      boost_roof_threshold,
    output logic [7:0]      input_current_limit_setting,
    output logic            hs_mode,
    output logic            nv_lock_status
);
    typedef enum {ST_IDLE, ST_ADDR, ST_PTR, ST_WDATA, ST_RDATA, ST_IGNORE} icns_state_e;

    // =========================================================
    // Pin sampling and bus conditions
    // =========================================================
    logic scl_s, sda_s, scl_p_q, sda_p_q;
    logic scl_rise, scl_fall, start_cond, stop_cond;

    icns_sync u_sync_scl (.clk_sys(clk_sys), .rst_b(rst_b), .async_in(scl_in), .sync_out(scl_s));
    icns_sync u_sync_sda (.clk_sys(clk_sys), .rst_b(rst_b), .async_in(sda_in), .sync_out(sda_s));

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    assign scl_rise   = scl_s && !scl_p_q;
    assign scl_fall   = !scl_s && scl_p_q;
    assign start_cond = scl_s && scl_p_q && sda_p_q && !sda_s;
    assign stop_cond  = scl_s && scl_p_q && !sda_p_q && sda_s;

    // Register read decode, shared by the read path and the pointer check.
    function automatic logic [7:0] reg_read(input logic [7:0] ptr, input logic [7:0] cfg,
                                            input logic [7:0] flo, input logic [7:0] roo,
                                            input logic [7:0] ilm, input logic [7:0] sts,
                                            input logic [7:0] nvc);
        case (ptr)
            icns_pkg::REG_CONFIG: reg_read = cfg;
            icns_pkg::REG_FLOOR:  reg_read = flo;
            icns_pkg::REG_ROOF:   reg_read = roo;
            icns_pkg::REG_ILIM:   reg_read = ilm;
            icns_pkg::REG_STATUS: reg_read = sts;
            icns_pkg::REG_NVCTRL: reg_read = nvc;
            default:              reg_read = 8'h00;
        endcase
    endfunction

    // =========================================================
    // Byte engine
    // =========================================================
    icns_state_e state_q;
    logic [3:0]  bit_q;
    logic [7:0]  shift_q, ptr_q, tx_q;
    logic        ack_phase_q, ack_drive_q, commit_pend_q, rnw_q;
    logic [7:0]  cfg_q, floor_q, roof_q, ilim_q, nvc_q;
    logic        load_done_q;
    logic [2:0]  load_cnt_q;
    logic        prog_req_q, prog_done, nv_locked;
    logic [7:0]  nv_config, nv_floor, nv_roof, nv_ilim;
    logic [7:0]  rd_byte;
    logic        wr_commit;
    logic [7:0]  wr_ptr, wr_val;

    assign rd_byte = reg_read(ptr_q, cfg_q, floor_q, roof_q, ilim_q, status_in,
                              {nvc_q[7:6], nv_locked, 5'h00});

    // The pointer takes the whole byte so out-of-map offsets read as zero.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_q       <= ST_IDLE;
            bit_q         <= 4'h0;
            shift_q       <= 8'h00;
            ptr_q         <= 8'h00;
            tx_q          <= 8'h00;
            ack_phase_q   <= 1'b0;
            ack_drive_q   <= 1'b0;
            commit_pend_q <= 1'b0;
            rnw_q         <= 1'b0;
            wr_commit     <= 1'b0;
            wr_ptr        <= 8'h00;
            wr_val        <= 8'h00;
        end else begin
            wr_commit <= 1'b0;
            if (stop_cond) begin
                state_q       <= ST_IDLE;
                ack_phase_q   <= 1'b0;
                ack_drive_q   <= 1'b0;
                commit_pend_q <= 1'b0;
            end else if (start_cond) begin
                state_q     <= ST_ADDR;
                bit_q       <= 4'h0;
                ack_phase_q <= 1'b0;
                ack_drive_q <= 1'b0;
            end else if (state_q != ST_IDLE && state_q != ST_IGNORE) begin
                if (scl_rise && !ack_phase_q) begin
                    shift_q <= {shift_q[6:0], sda_s};
                    bit_q   <= bit_q + 4'h1;
                end
                if (scl_rise && ack_phase_q && state_q == ST_RDATA && sda_s) begin
                    state_q <= ST_IGNORE;
                end
                if (scl_fall) begin
                    if (ack_phase_q) begin
                        ack_phase_q <= 1'b0;
                        ack_drive_q <= 1'b0;
                        bit_q       <= 4'h0;
                        if (commit_pend_q) begin
                            wr_commit     <= 1'b1;
                            commit_pend_q <= 1'b0;
                        end
                        if (state_q == ST_RDATA) begin
                            tx_q <= rd_byte;
                        end
                    end else if (bit_q == 4'h8) begin
                        ack_phase_q <= 1'b1;
                        case (state_q)
                            ST_ADDR: begin
                                if (shift_q[7:3] == icns_pkg::HS_CODE_TOP) begin
                                    state_q <= ST_IGNORE;
                                end else if (shift_q[7:1] == icns_pkg::SLAVE_ADDR) begin
                                    ack_drive_q <= 1'b1;
                                    rnw_q       <= shift_q[0];
                                    state_q     <= shift_q[0] ? ST_RDATA : ST_PTR;
                                    tx_q        <= rd_byte;
                                end else begin
                                    state_q <= ST_IGNORE;
                                end
                            end
                            ST_PTR: begin
                                ptr_q       <= shift_q;
                                ack_drive_q <= 1'b1;
                                state_q     <= ST_WDATA;
                            end
                            ST_WDATA: begin
                                ack_drive_q   <= 1'b1;
                                commit_pend_q <= 1'b1;
                                wr_ptr        <= ptr_q;
                                wr_val        <= shift_q;
                            end
                            ST_RDATA: ack_drive_q <= 1'b0;
                            default:  state_q <= ST_IGNORE;
                        endcase
                    end else if (state_q == ST_RDATA && bit_q != 4'h0) begin
                        tx_q <= {tx_q[6:0], 1'b0};
                    end
                end
            end
        end
    end

    // Level changes only on clock falls, or releases on start and stop, so data is stable across the high phase.
    // The first bit of a read byte leaves on the fall that closes the acknowledge.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sda_oe_b <= 1'b1;
            sda_out  <= 1'b0;
        end else begin
            sda_out <= 1'b0;
            if (stop_cond || start_cond) begin
                sda_oe_b <= 1'b1;
            end else if (scl_fall) begin
                if (!ack_phase_q && bit_q == 4'h8) begin
                    sda_oe_b <= !(state_q == ST_PTR || state_q == ST_WDATA ||
                                  (state_q == ST_ADDR && shift_q[7:1] == icns_pkg::SLAVE_ADDR
                                   && shift_q[7:3] != icns_pkg::HS_CODE_TOP));
                end else if (state_q == ST_RDATA && (ack_phase_q || bit_q != 4'h8)) begin
                    sda_oe_b <= (ack_phase_q || bit_q == 4'h0) ? rd_byte[7] : tx_q[6];
                end else begin
                    sda_oe_b <= 1'b1;
                end
            end
        end
    end

    // High-speed mode flag: set on master code, cleared by stop.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            hs_mode <= 1'b0;
        end else if (stop_cond) begin
            hs_mode <= 1'b0;
        end else if (scl_fall && state_q == ST_ADDR && bit_q == 4'h8 && !ack_phase_q
                     && shift_q[7:3] == icns_pkg::HS_CODE_TOP) begin
            hs_mode <= 1'b1;
        end
    end

    // =========================================================
    // Register file, power-up load and store trigger
    // =========================================================
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            load_done_q <= 1'b0;
            load_cnt_q  <= 3'h0;
            cfg_q       <= icns_pkg::CONFIG_DEFAULT;
            floor_q     <= icns_pkg::FLOOR_DEFAULT;
            roof_q      <= icns_pkg::ROOF_DEFAULT;
            ilim_q      <= icns_pkg::ILIM_DEFAULT;
        end else if (!load_done_q) begin
            load_cnt_q <= load_cnt_q + 3'h1;
            if (load_cnt_q == 3'(icns_pkg::LOAD_CYC - 1)) begin
                load_done_q <= 1'b1;
                cfg_q       <= nv_config;
                floor_q     <= nv_floor;
                roof_q      <= nv_roof;
                ilim_q      <= nv_ilim;
            end
        end else if (wr_commit) begin
            case (wr_ptr)
                icns_pkg::REG_CONFIG: cfg_q   <= wr_val & icns_pkg::MASK_CONFIG;
                icns_pkg::REG_FLOOR:  floor_q <= wr_val & icns_pkg::MASK_FLOOR;
                icns_pkg::REG_ROOF:   roof_q  <= wr_val & icns_pkg::MASK_ROOF;
                icns_pkg::REG_ILIM:   ilim_q  <= wr_val & icns_pkg::MASK_ILIM;
                default:              ;
            endcase
        end
    end

    // A trigger written while locked clears immediately; the store is left untouched.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            nvc_q      <= icns_pkg::NVCTRL_RESET;
            prog_req_q <= 1'b0;
        end else begin
            prog_req_q <= 1'b0;
            if (wr_commit && wr_ptr == icns_pkg::REG_NVCTRL) begin
                nvc_q <= {wr_val[7:6], 6'h00};
                if (wr_val[icns_pkg::NV_TRIG_BIT] && !nv_locked) begin
                    prog_req_q <= 1'b1;
                end else if (wr_val[icns_pkg::NV_TRIG_BIT]) begin
                    nvc_q[icns_pkg::NV_TRIG_BIT] <= 1'b0;
                end
            end else if (prog_done) begin
                nvc_q[icns_pkg::NV_TRIG_BIT] <= 1'b0;
            end
        end
    end

    icns_nvstore u_nv (
        .clk_sys    (clk_sys),
        .rst_b      (rst_b),
        .prog_req   (prog_req_q),
        .prog_config(cfg_q & icns_pkg::NV_STORE_MASK),
        .prog_floor (floor_q),
        .prog_roof  (roof_q),
        .prog_ilim  (ilim_q & icns_pkg::NV_ILIM_MASK),
        .prog_wp    (nvc_q[icns_pkg::NV_WP_BIT]),
        .prog_done  (prog_done),
        .nv_config  (nv_config),
        .nv_floor   (nv_floor),
        .nv_roof    (nv_roof),
        .nv_ilim    (nv_ilim),
        .nv_locked  (nv_locked)
    );

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            device_config               <= 8'h00;
            boost_floor_threshold       <= 8'h00;
            boost_roof_threshold        <= 8'h00;
            input_current_limit_setting <= 8'h00;
            nv_lock_status              <= 1'b0;
        end else begin
            device_config               <= cfg_q;
            boost_floor_threshold       <= floor_q;
            boost_roof_threshold        <= roof_q;
            input_current_limit_setting <= ilim_q;
            nv_lock_status              <= nv_locked;
        end
    end

    // =========================================================
    // Checks
    // =========================================================
    a_ack_only_match: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $fell(sda_oe_b) && ack_phase_q |-> state_q != ST_IGNORE)
        else $error("ack driven for ignored address");
    a_drive_on_fall: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $changed(sda_oe_b) |-> $past(scl_fall) || $past(stop_cond) || $past(start_cond))
        else $error("data changed outside clock low");
    a_stop_release: assert property (@(posedge clk_sys) disable iff (!rst_b)
        stop_cond |=> sda_oe_b && state_q == ST_IDLE)
        else $error("bus not released after stop");
    a_hs_exit: assert property (@(posedge clk_sys) disable iff (!rst_b)
        stop_cond |=> !hs_mode)
        else $error("high-speed kept after stop");
    a_commit_time: assert property (@(posedge clk_sys) disable iff (!rst_b)
        wr_commit |-> $past(scl_fall) && $past(ack_phase_q))
        else $error("commit off the acknowledge fall");
    a_lock_sticky: assert property (@(posedge clk_sys) disable iff (!rst_b)
        nv_locked |=> nv_locked)
        else $error("store lock released");
    a_lock_no_prog: assert property (@(posedge clk_sys) disable iff (!rst_b)
        nv_locked |-> !prog_req_q)
        else $error("store programmed while locked");
    a_trig_clears: assert property (@(posedge clk_sys) disable iff (!rst_b)
        prog_done |=> !nvc_q[icns_pkg::NV_TRIG_BIT])
        else $error("trigger bit not cleared");
    a_load_ready: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(load_done_q) |-> cfg_q == $past(nv_config))
        else $error("power-up load missed");

    // Byte and bit boundaries that the checks below start from.
    sequence s_code_end;
        scl_fall && !ack_phase_q && bit_q == 4'h8 && state_q == ST_ADDR
            && shift_q[7:3] == icns_pkg::HS_CODE_TOP;
    endsequence

    sequence s_recv_end;
        scl_fall && !ack_phase_q && bit_q == 4'h8
            && (state_q == ST_PTR || state_q == ST_WDATA);
    endsequence

    sequence s_ack_close;
        scl_fall && ack_phase_q && state_q == ST_RDATA;
    endsequence

    sequence s_bit_close;
        scl_fall && !ack_phase_q && state_q == ST_RDATA && bit_q != 4'h0 && bit_q != 4'h8;
    endsequence

    a_code_no_ack: assert property (@(posedge clk_sys) disable iff (!rst_b)
        s_code_end |=> sda_oe_b && hs_mode)
        else $error("master code acknowledged");
    a_byte_ack: assert property (@(posedge clk_sys) disable iff (!rst_b)
        s_recv_end |=> !sda_oe_b && ack_drive_q)
        else $error("received byte not acknowledged");
    a_ack_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ack_drive_q |-> !sda_oe_b)
        else $error("acknowledge released early");
    a_first_bit: assert property (@(posedge clk_sys) disable iff (!rst_b)
        s_ack_close |=> sda_oe_b == tx_q[7])
        else $error("first read bit wrong");
    a_next_bit: assert property (@(posedge clk_sys) disable iff (!rst_b)
        s_bit_close |=> sda_oe_b == tx_q[7])
        else $error("read bit wrong");
    a_unmapped_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ptr_q > icns_pkg::REG_STATUS && ptr_q != icns_pkg::REG_NVCTRL
            |-> rd_byte == 8'h00)
        else $error("unmapped register not zero");
endmodule // icns_slave
`default_nettype wire

// ### bench/icns_master.sv
// Behavioural bus master that drives the serial clock and the data line.
`timescale 1ns/1ps
`default_nettype none
module icns_master (
    output logic      scl,
    output logic      sda_oe_b,
    input  wire logic sda
);
    // ==========================================
    // Bit timing
    // A quarter of the 125 ns link period; the clock stands high between frames.
    localparam realtime QTR = 31.25;

    initial begin
        scl = 1'b1;
        sda_oe_b = 1'b1;
    end

    task automatic start();
        sda_oe_b = 1'b1;
        #QTR scl = 1'b1;
        #QTR sda_oe_b = 1'b0;
        #QTR scl = 1'b0;
        #QTR;
    endtask

    // The long tail gives the slave's synchronisers time to see the free bus.
    task automatic stop();
        sda_oe_b = 1'b0;
        #QTR scl = 1'b1;
        #QTR sda_oe_b = 1'b1;
        #(4 * QTR);
    endtask

    task automatic xbit(input logic b, output logic r);
        sda_oe_b = b;
        #QTR scl = 1'b1;
        #QTR r = sda;
        #QTR scl = 1'b0;
        #QTR;
    endtask

    task automatic xbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xbit(d[i], r);
        end
        xbit(1'b1, r);
        ack = ~r;
    endtask

    task automatic rbyte(output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xbit(1'b1, r);
            d[i] = r;
        end
        xbit(1'b1, r);
    endtask
endmodule // icns_master
`default_nettype wire

// ### bench/icns_slave_bench.sv
// Self-checking bench for the serial configuration slave.
`timescale 1ns/1ps
`default_nettype none
module icns_slave_bench;
    logic        clk_sys   = 1'b0;
    logic        rst_b     = 1'b0;
    logic [7:0]  status_in = 8'h5a;
    wire logic   scl, m_oe_b, s_out, s_oe_b, hs_mode, nv_lock_status;
    wire logic [7:0] cfg, flo, roo, ilm;
    wire logic   sda = m_oe_b & (s_oe_b | s_out);
    int          bad_count  = 0;
    int          n_compared = 0;
    logic [7:0]  rd_val;
    logic        ack_seen;
    logic [23:0] rows [7] = '{24'h01ffef, 24'h02ff1f, 24'h03a505, 24'h04ff3f,
                              24'h05005a, 24'h063300, 24'h814400};
    logic [7:0]  bad_addr [3] = '{8'hec, 8'h00, 8'hf0};

    always #4 clk_sys = ~clk_sys;

    icns_master icns_master_inst (.scl(scl), .sda_oe_b(m_oe_b), .sda(sda));

    icns_slave icns_slave_inst (
        .clk_sys(clk_sys), .rst_b(rst_b), .scl_in(scl), .sda_in(sda),
        .sda_out(s_out), .sda_oe_b(s_oe_b), .status_in(status_in),
        .device_config(cfg), .boost_floor_threshold(flo), .boost_roof_threshold(roo),
        .input_current_limit_setting(ilm), .hs_mode(hs_mode),
        .nv_lock_status(nv_lock_status));

    // ==========================================
    // Checks and bus sequences
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        logic a0, a1, a2;
        icns_master_inst.start();
        icns_master_inst.xbyte({icns_pkg::SLAVE_ADDR, 1'b0}, a0);
        icns_master_inst.xbyte(p, a1);
        icns_master_inst.xbyte(d, a2);
        icns_master_inst.stop();
        chk("write acks", 8'h07, {5'h00, a0, a1, a2});
    endtask

    task automatic rd(input logic [7:0] p);
        logic a0, a1, a2;
        icns_master_inst.start();
        icns_master_inst.xbyte({icns_pkg::SLAVE_ADDR, 1'b0}, a0);
        icns_master_inst.xbyte(p, a1);
        icns_master_inst.start();
        icns_master_inst.xbyte({icns_pkg::SLAVE_ADDR, 1'b1}, a2);
        icns_master_inst.rbyte(rd_val);
        icns_master_inst.stop();
        chk("read acks", 8'h07, {5'h00, a0, a1, a2});
    endtask

    task automatic final_report();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ==========================================
    // Main sequence
    initial begin
        repeat (20) @(posedge clk_sys);
        #1 rst_b = 1'b1;
        repeat (10) @(posedge clk_sys);
        icns_master_inst.stop();
        chk("loaded config", icns_pkg::CONFIG_DEFAULT, cfg);
        chk("loaded floor", icns_pkg::FLOOR_DEFAULT, flo);
        chk("loaded roof", icns_pkg::ROOF_DEFAULT, roo);
        chk("loaded limit", icns_pkg::ILIM_DEFAULT, ilm);
        rd(icns_pkg::REG_NVCTRL);
        chk("store control", icns_pkg::NVCTRL_RESET, rd_val);
        foreach (rows[i]) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16]);
            chk("row readback", rows[i][7:0], rd_val);
        end
        chk("config output", 8'hef, cfg);
        chk("roof output", 8'h05, roo);
        // Foreign, general-call and ten-bit leading bytes must all go unanswered.
        foreach (bad_addr[i]) begin
            icns_master_inst.start();
            icns_master_inst.xbyte(bad_addr[i], ack_seen);
            icns_master_inst.stop();
            chk("refused ack", 8'h00, {7'h00, ack_seen});
        end
        icns_master_inst.start();
        icns_master_inst.xbyte(8'h09, ack_seen);
        chk("master code ack", 8'h00, {7'h00, ack_seen});
        chk("fast flag set", 8'h01, {7'h00, hs_mode});
        wr(icns_pkg::REG_FLOOR, 8'h0a);
        chk("fast flag clear", 8'h00, {7'h00, hs_mode});
        wr(icns_pkg::REG_NVCTRL, 8'hc0);
        for (int n = 0; n < 400 && nv_lock_status !== 1'b1; n++) begin
            @(posedge clk_sys);
        end
        chk("lock status", 8'h01, {7'h00, nv_lock_status});
        rd(icns_pkg::REG_NVCTRL);
        chk("locked control", 8'h20, rd_val & 8'ha0);
        wr(icns_pkg::REG_NVCTRL, 8'h80);
        rd(icns_pkg::REG_NVCTRL);
        chk("refused trigger", 8'h20, rd_val & 8'ha0);
        rd(icns_pkg::REG_FLOOR);
        chk("read while locked", 8'h0a, rd_val);
        // A mid-run reset must release the line and run the power-up load again.
        @(posedge clk_sys);
        #1 rst_b = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        chk("reset config", 8'h00, cfg);
        chk("reset line", 8'h02, {6'h00, s_oe_b, s_out});
        rst_b = 1'b1;
        repeat (10) @(posedge clk_sys);
        #1;
        chk("reloaded config", icns_pkg::CONFIG_DEFAULT, cfg);
        final_report();
    end
endmodule // icns_slave_bench
`default_nettype wire
